//--- pfbc_pkg.sv
// constants shared by the fetch front end and its memory bus sequencer
`default_nettype none
package pfbc_pkg;
  localparam int QDEPTH      = 6;
  localparam int NWAY        = 4;
  localparam int MCYCLE_CLKS = 4;
  localparam int STD_MCYCLE  = 12;
  localparam int WAITS_5V    = 4;
  localparam int WAITS_3V3   = 5;
  localparam int AW          = 16;
  localparam int WW          = 3;
  // bus control register layout
  localparam int BCR_W       = 8;
  localparam int BCR_CW_LSB  = 0;
  localparam int BCR_DW_LSB  = 3;
  localparam int BCR_SEP_BIT = 6;
  localparam int BCR_EN_BIT  = 7;
  localparam logic [BCR_W-1:0] BCR_RST_5V  = 8'ha4;
  localparam logic [BCR_W-1:0] BCR_RST_3V3 = 8'had;
  typedef logic [7:0]    pfbc_byte_t;
  typedef logic [AW-1:0] pfbc_addr_t;
  typedef logic [WW-1:0] pfbc_wait_t;
endpackage : pfbc_pkg
`default_nettype wire

//--- pfbc_bus_if.sv
// request and answer signals between front end and bus sequencer
`timescale 1ns/1ps
`default_nettype none
interface pfbc_bus_if;
  import pfbc_pkg::*;
  logic        req;
  logic        code;
  logic        we;
  pfbc_addr_t  addr;
  pfbc_byte_t  wdata;
  pfbc_wait_t  waits;
  logic        busy;
  logic        code_done;
  logic        data_done;
  pfbc_byte_t  rdata;
  modport ctl (output req, code, we, addr, wdata, waits,
               input busy, code_done, data_done, rdata);
  modport seq (input req, code, we, addr, wdata, waits,
               output busy, code_done, data_done, rdata);
endinterface : pfbc_bus_if
`default_nettype wire

//--- pfbc_bus_seq.sv
// program memory bus sequencer with programmable wait states
`timescale 1ns/1ps
`default_nettype none
module pfbc_bus_seq (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  pfbc_bus_if.seq            bus,
  input  wire pfbc_pkg::pfbc_byte_t pm_rdata,
  output var  pfbc_pkg::pfbc_addr_t pm_addr,
  output var  pfbc_pkg::pfbc_byte_t pm_wdata,
  output var  logic          pm_rd,
  output var  logic          pm_wr,
  output var  logic          pm_code
);
  import pfbc_pkg::*;
  logic       busy_q;
  pfbc_wait_t wcnt_q;
  logic       cdone_q;
  logic       ddone_q;
  pfbc_byte_t rdata_q;
  logic [3:0] span_q;
  pfbc_wait_t wlat_q;

  assign bus.busy      = busy_q;
  assign bus.code_done = cdone_q;
  assign bus.data_done = ddone_q;
  assign bus.rdata     = rdata_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q  <= 1'b0;
      wcnt_q  <= '0;
      cdone_q <= 1'b0;
      ddone_q <= 1'b0;
      rdata_q <= '0;
      pm_addr <= '0;
      pm_wdata <= '0;
      pm_rd   <= 1'b0;
      pm_wr   <= 1'b0;
      pm_code <= 1'b0;
    end else begin
      cdone_q <= 1'b0;
      ddone_q <= 1'b0;
      if (!busy_q && bus.req) begin
        busy_q   <= 1'b1;
        wcnt_q   <= bus.waits;
        pm_addr  <= bus.addr;
        pm_wdata <= bus.wdata;
        pm_rd    <= !bus.we;
        pm_wr    <= bus.we;
        pm_code  <= bus.code;
      end else if (busy_q && wcnt_q != '0) begin
        wcnt_q <= wcnt_q - 3'd1;
      end else if (busy_q) begin
        busy_q  <= 1'b0;
        pm_rd   <= 1'b0;
        pm_wr   <= 1'b0;
        rdata_q <= pm_rdata;
        cdone_q <= pm_code;
        ddone_q <= !pm_code;
      end
    end
  end

  // strobe length counter seen only by the check below
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      span_q <= '0;
      wlat_q <= '0;
    end else if (!busy_q && bus.req) begin
      // counts clocks with a strobe high, so a finished access reads waits plus one
      span_q <= 4'd0;
      wlat_q <= bus.waits;
    end else if (pm_rd || pm_wr) begin
      span_q <= span_q + 4'd1;
    end
  end

  property p_wait_span;
    @(posedge clk_sys) disable iff (sys_rst)
      (cdone_q || ddone_q) |-> (span_q == {1'b0, wlat_q} + 4'd1);
  endproperty
  a_wait_span: assert property (p_wait_span)
    else $error("strobe length differs from wait count");
endmodule : pfbc_bus_seq
`default_nettype wire

//--- pfbc_front.sv
// prefetch queue and branch target cache of the core fetch front end
`timescale 1ns/1ps
`default_nettype none
module pfbc_front #(
  parameter bit LOW_VOLT = 1'b0
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 bcr_wr,
  input  wire pfbc_pkg::pfbc_byte_t bcr_wdata,
  output var  pfbc_pkg::pfbc_byte_t bcr_rdata,
  input  wire logic                 branch_req,
  input  wire pfbc_pkg::pfbc_addr_t branch_addr,
  input  wire logic                 fetch_req,
  input  wire logic [1:0]           fetch_len,
  output var  logic                 instr_valid,
  output var  logic [23:0]          instr_bytes,
  output var  logic                 core_stall,
  output var  logic                 mcycle_tick,
  output var  logic                 bc_hit,
  input  wire logic                 dat_req,
  input  wire logic                 dat_we,
  input  wire pfbc_pkg::pfbc_addr_t dat_addr,
  input  wire pfbc_pkg::pfbc_byte_t dat_wdata,
  output var  logic                 dat_done,
  output var  pfbc_pkg::pfbc_byte_t dat_rdata,
  input  wire pfbc_pkg::pfbc_byte_t pm_rdata,
  output var  pfbc_pkg::pfbc_addr_t pm_addr,
  output var  pfbc_pkg::pfbc_byte_t pm_wdata,
  output var  logic                 pm_rd,
  output var  logic                 pm_wr,
  output var  logic                 pm_code
);
  import pfbc_pkg::*;

  pfbc_bus_if bus ();

  pfbc_bus_seq u_seq (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .bus      (bus.seq),
    .pm_rdata (pm_rdata),
    .pm_addr  (pm_addr),
    .pm_wdata (pm_wdata),
    .pm_rd    (pm_rd),
    .pm_wr    (pm_wr),
    .pm_code  (pm_code)
  );

  localparam logic [BCR_W-1:0] BCR_RST = LOW_VOLT ? BCR_RST_3V3 : BCR_RST_5V;

  function automatic logic [1:0] way_of(input logic [NWAY-1:0] v);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 0; i < NWAY; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // ---- bus control register
  logic       en;
  logic       sep;
  pfbc_wait_t cwait;
  pfbc_wait_t dwait;
  assign en    = bcr_rdata[BCR_EN_BIT];
  assign sep   = bcr_rdata[BCR_SEP_BIT];
  assign cwait = bcr_rdata[BCR_CW_LSB +: WW];
  assign dwait = bcr_rdata[BCR_DW_LSB +: WW];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bcr_rdata <= BCR_RST;
    end else if (bcr_wr) begin
      bcr_rdata <= bcr_wdata;
    end
  end

  // ---- machine cycle timer
  logic [1:0] mc_q;
  logic       mc_last;
  assign mc_last = (mc_q == 2'(MCYCLE_CLKS - 1));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mc_q        <= '0;
      mcycle_tick <= 1'b0;
    end else begin
      mc_q        <= mc_q + 2'd1;
      mcycle_tick <= mc_last;
    end
  end

  // ---- branch target cache storage
  logic [NWAY-1:0] vld_q;
  pfbc_addr_t      tag_q [NWAY];
  pfbc_byte_t      cbyte_q [NWAY][QDEPTH];
  logic [2:0]      clen_q [NWAY];
  logic [1:0]      age_q [NWAY];
  logic [NWAY-1:0] hit_v;
  logic [NWAY-1:0] lru_v;
  logic            hit;
  logic [1:0]      hway;
  logic [1:0]      vway;

  for (genvar g = 0; g < NWAY; g++) begin : g_cmp
    assign hit_v[g] = vld_q[g] && (tag_q[g] == branch_addr);
    assign lru_v[g] = (age_q[g] == 2'(NWAY - 1));
  end
  assign hit  = en && (hit_v != '0);
  assign hway = way_of(hit_v);
  assign vway = way_of(lru_v);

  // ---- queue state
  pfbc_byte_t q_q [QDEPTH];
  logic [2:0] cnt_q;
  pfbc_addr_t faddr_q;
  logic       cpend_q;
  logic       drop_q;
  logic       dpend_q;
  logic       fill_q;
  logic [1:0] fway_q;
  logic [2:0] flen_q;

  logic       deliver;
  logic       push;
  logic       room;
  logic       issue_code;
  logic       issue_data;
  logic [2:0] pop_n;

  assign deliver = mc_last && fetch_req && fetch_len != 2'd0 &&
                   cnt_q >= {1'b0, fetch_len} && !branch_req;
  assign pop_n   = deliver ? {1'b0, fetch_len} : 3'd0;
  assign push    = bus.code_done && !drop_q && !branch_req;

  always_comb begin
    if (en) begin
      room = ({1'b0, cnt_q} + {3'd0, cpend_q}) < 4'(QDEPTH);
    end else begin
      room = fetch_req &&
             ({1'b0, cnt_q} + {3'd0, cpend_q}) < {2'd0, fetch_len};
    end
  end

  // code reads fill idle bus time while en is set; with en clear they are issued only for fetch demand
  assign issue_data = dat_req && !dpend_q && !bus.busy;
  assign issue_code = !issue_data && !dat_req && !bus.busy &&
                      !cpend_q && room && !branch_req;

  assign bus.req   = issue_data || issue_code;
  assign bus.code  = !issue_data;
  assign bus.we    = issue_data && dat_we;
  assign bus.addr  = issue_data ? dat_addr : faddr_q;
  assign bus.wdata = dat_wdata;
  assign bus.waits = (issue_data && sep) ? dwait : cwait;

  // queue next value
  pfbc_byte_t q_d [QDEPTH];
  logic [2:0] cnt_d;
  always_comb begin
    for (int i = 0; i < QDEPTH; i++) begin
      q_d[i] = '0;
    end
    cnt_d = cnt_q;
    if (branch_req) begin
      if (hit) begin
        for (int i = 0; i < QDEPTH; i++) begin
          q_d[i] = cbyte_q[hway][i];
        end
        cnt_d = clen_q[hway];
      end else begin
        cnt_d = 3'd0;
      end
    end else begin
      for (int i = 0; i < QDEPTH; i++) begin
        if (i + int'(pop_n) < QDEPTH) begin
          q_d[i] = q_q[i + int'(pop_n)];
        end
      end
      cnt_d = cnt_q - pop_n;
      if (push) begin
        q_d[cnt_d] = bus.rdata;
        cnt_d      = cnt_d + 3'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= '0;
      for (int i = 0; i < QDEPTH; i++) begin
        q_q[i] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      q_q   <= q_d;
    end
  end

  // fetch address and outstanding accesses
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      faddr_q <= '0;
      cpend_q <= 1'b0;
      drop_q  <= 1'b0;
      dpend_q <= 1'b0;
    end else begin
      if (branch_req) begin
        faddr_q <= hit ? branch_addr + AW'(clen_q[hway]) : branch_addr;
      end else if (issue_code) begin
        faddr_q <= faddr_q + 16'h0001;
      end
      if (issue_code) begin
        cpend_q <= 1'b1;
      end else if (bus.code_done) begin
        cpend_q <= 1'b0;
      end
      // read in flight at a branch is not queued
      if (bus.code_done) begin
        drop_q <= 1'b0;
      end else if (branch_req && cpend_q) begin
        drop_q <= 1'b1;
      end
      if (issue_data) begin
        dpend_q <= 1'b1;
      end else if (bus.data_done) begin
        dpend_q <= 1'b0;
      end
    end
  end

  // ---- cache fill, replacement and invalidation
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vld_q  <= '0;
      fill_q <= 1'b0;
      fway_q <= '0;
      flen_q <= '0;
      for (int w = 0; w < NWAY; w++) begin
        tag_q[w]  <= '0;
        clen_q[w] <= '0;
        age_q[w]  <= 2'(w);
        for (int i = 0; i < QDEPTH; i++) begin
          cbyte_q[w][i] <= '0;
        end
      end
    end else if (!en) begin
      vld_q  <= '0;
      fill_q <= 1'b0;
    end else if (branch_req) begin
      for (int w = 0; w < NWAY; w++) begin
        if (age_q[w] < age_q[hit ? hway : vway]) begin
          age_q[w] <= age_q[w] + 2'd1;
        end
      end
      age_q[hit ? hway : vway] <= 2'd0;
      fill_q <= !hit;
      if (!hit) begin
        vld_q[vway]  <= 1'b0;
        tag_q[vway]  <= branch_addr;
        clen_q[vway] <= 3'd0;
        fway_q       <= vway;
        flen_q       <= 3'd0;
      end
    end else if (fill_q && push) begin
      cbyte_q[fway_q][flen_q] <= bus.rdata;
      clen_q[fway_q]          <= flen_q + 3'd1;
      vld_q[fway_q]           <= 1'b1;
      flen_q                  <= flen_q + 3'd1;
      fill_q                  <= (flen_q != 3'(QDEPTH - 1));
    end
  end

  // ---- outputs to core
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      instr_valid <= 1'b0;
      instr_bytes <= '0;
      core_stall  <= 1'b0;
      bc_hit      <= 1'b0;
      dat_done    <= 1'b0;
      dat_rdata   <= '0;
    end else begin
      instr_valid <= deliver;
      if (deliver) begin
        instr_bytes <= {q_q[2], q_q[1], q_q[0]};
      end
      core_stall <= fetch_req && fetch_len != 2'd0 &&
                    (branch_req || cnt_q < {1'b0, fetch_len});
      bc_hit     <= branch_req && hit;
      dat_done   <= bus.data_done;
      if (bus.data_done) begin
        dat_rdata <= bus.rdata;
      end
    end
  end

  // ---- checks
  sequence s_tick_gap;
    !mcycle_tick [*3] ##1 mcycle_tick;
  endsequence
  property p_mcycle;
    @(posedge clk_sys) disable iff (sys_rst)
      mcycle_tick && $past(mcycle_tick) == 1'b0 |=> s_tick_gap;
  endproperty
  a_mcycle: assert property (p_mcycle)
    else $error("machine cycle is not four clocks");

  property p_qmax;
    @(posedge clk_sys) disable iff (sys_rst)
      ({1'b0, cnt_q} + {3'd0, cpend_q}) <= 4'(QDEPTH);
  endproperty
  a_qmax: assert property (p_qmax)
    else $error("queue holds more than six bytes");

  property p_demand;
    @(posedge clk_sys) disable iff (sys_rst)
      (issue_code && !en) |-> fetch_req && cnt_q < {1'b0, fetch_len};
  endproperty
  a_demand: assert property (p_demand)
    else $error("code read issued without demand");

  property p_hit_load;
    @(posedge clk_sys) disable iff (sys_rst)
      (branch_req && hit) |=> bc_hit && cnt_q == $past(clen_q[hway]);
  endproperty
  a_hit_load: assert property (p_hit_load)
    else $error("hit did not load entry into queue");

  property p_miss_flush;
    @(posedge clk_sys) disable iff (sys_rst)
      (branch_req && !hit) |=> cnt_q == 3'd0 && faddr_q == $past(branch_addr);
  endproperty
  a_miss_flush: assert property (p_miss_flush)
    else $error("miss did not flush and retarget");

  property p_rst_en;
    @(posedge clk_sys) sys_rst |=> en;
  endproperty
  a_rst_en: assert property (p_rst_en)
    else $error("queue not enabled after reset");

  property p_dis_inval;
    @(posedge clk_sys) disable iff (sys_rst)
      !en |=> vld_q == '0 && !bc_hit;
  endproperty
  a_dis_inval: assert property (p_dis_inval)
    else $error("cache valid while disabled");

  property p_stall;
    @(posedge clk_sys) disable iff (sys_rst)
      (fetch_req && fetch_len != 2'd0 && cnt_q == 3'd0) |=>
        core_stall && !instr_valid;
  endproperty
  a_stall: assert property (p_stall)
    else $error("core not stalled on empty queue");

  property p_idle_fetch;
    @(posedge clk_sys) disable iff (sys_rst)
      (en && !bus.busy && !dat_req && !cpend_q && !branch_req &&
       cnt_q < 3'(QDEPTH - 1)) |-> ##[0:1] bus.req;
  endproperty
  a_idle_fetch: assert property (p_idle_fetch)
    else $error("idle bus not used for prefetch");
endmodule : pfbc_front
`default_nettype wire

//--- pfbc_pmem_model.sv
// program memory model answering the fetch front end's bus strobes
`timescale 1ns/1ps
`default_nettype none
module pfbc_pmem_model (
  input  wire logic                 clk_sys,
  input  wire pfbc_pkg::pfbc_addr_t pm_addr,
  input  wire logic                 pm_rd,
  output var  pfbc_pkg::pfbc_byte_t pm_rdata
);
  import pfbc_pkg::*;
  pfbc_byte_t last_q;
  // a released bus shows the inverse of the last byte, then alternates each clock with that byte itself
  always_comb begin
    if (pm_rd) begin
      pm_rdata = pm_addr[7:0] ^ pm_addr[15:8] ^ 8'h5a;
    end else begin
      pm_rdata = ~last_q;
    end
  end
  always_ff @(posedge clk_sys) begin
    last_q <= pm_rdata;
  end
endmodule : pfbc_pmem_model
`default_nettype wire

//--- prefetch_queue_branch_cache_test.sv
// self-checking bench for the fetch front end
`timescale 1ns/1ps
`default_nettype none
`define PFBC_CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module prefetch_queue_branch_cache_test;
  import pfbc_pkg::*;
  logic       clk_sys, sys_rst, bcr_wr, branch_req, fetch_req;
  logic       dat_req, dat_we, instr_valid, core_stall, mcycle_tick;
  logic       bc_hit, dat_done, pm_rd, pm_wr, pm_code;
  logic [1:0] fetch_len;
  logic [23:0] instr_bytes;
  pfbc_byte_t bcr_wdata, bcr_rdata, dat_wdata, dat_rdata, pm_rdata, pm_wdata;
  pfbc_addr_t branch_addr, dat_addr, pm_addr, pc;
  int         error_cnt, total_checks, rd_run, last_len, code_reads, base;
  logic       rd_prev, stall_seen;

  pfbc_front #(.LOW_VOLT(1'b0)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bcr_wr(bcr_wr),
    .bcr_wdata(bcr_wdata), .bcr_rdata(bcr_rdata), .branch_req(branch_req),
    .branch_addr(branch_addr), .fetch_req(fetch_req),
    .fetch_len(fetch_len), .instr_valid(instr_valid),
    .instr_bytes(instr_bytes), .core_stall(core_stall),
    .mcycle_tick(mcycle_tick), .bc_hit(bc_hit), .dat_req(dat_req),
    .dat_we(dat_we), .dat_addr(dat_addr), .dat_wdata(dat_wdata),
    .dat_done(dat_done), .dat_rdata(dat_rdata), .pm_rdata(pm_rdata),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_rd(pm_rd), .pm_wr(pm_wr),
    .pm_code(pm_code));
  pfbc_pmem_model u_mem (
    .clk_sys(clk_sys), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // strobe length of the last access and count of code reads begun
  always @(posedge clk_sys) begin
    if (pm_rd || pm_wr) begin
      rd_run <= rd_run + 1;
    end else if (rd_run != 0) begin
      last_len <= rd_run;
      rd_run <= 0;
    end
    if (pm_rd && !rd_prev && pm_code) begin
      code_reads <= code_reads + 1;
    end
    rd_prev <= pm_rd;
  end

  function automatic pfbc_byte_t mem_val(input pfbc_addr_t a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bcr_write(input pfbc_byte_t v);
    bcr_wr = 1'b1;
    bcr_wdata = v;
    tick(1);
    bcr_wr = 1'b0;
    tick(1);
    `PFBC_CHK(bcr_rdata, v)
  endtask

  task automatic do_branch(input pfbc_addr_t a, input logic exp_hit);
    branch_req = 1'b1;
    branch_addr = a;
    pc = a;
    tick(1);
    branch_req = 1'b0;
    `PFBC_CHK(bc_hit, exp_hit)
  endtask

  // core asks for len bytes, waits for delivery, checks program order
  task automatic fetch(input int len);
    int i;
    fetch_req = 1'b1;
    fetch_len = 2'(len);
    stall_seen = 1'b0;
    for (i = 0; i < 80; i++) begin
      tick(1);
      if (core_stall === 1'b1) stall_seen = 1'b1;
      if (instr_valid === 1'b1) break;
    end
    fetch_req = 1'b0;
    if (i == 80) error_cnt++;
    for (i = 0; i < len; i++) begin
      `PFBC_CHK(instr_bytes[8*i +: 8], mem_val(pc + 16'(i)))
    end
    // let an edge pass before the next request raises fetch_req again
    tick(1);
    pc = pc + 16'(len);
  endtask

  task automatic data_read(input pfbc_addr_t a, input int exp_len);
    int i;
    dat_req = 1'b1;
    dat_addr = a;
    for (i = 0; i < 40; i++) begin
      tick(1);
      if (dat_done === 1'b1) break;
    end
    dat_req = 1'b0;
    if (i == 40) error_cnt++;
    `PFBC_CHK(dat_rdata, mem_val(a))
    `PFBC_CHK(last_len, exp_len)
  endtask

  // data write: strobe length, address and write data seen on the bus
  task automatic data_write(input pfbc_addr_t a, input pfbc_byte_t v,
                            input int exp_len);
    int i;
    dat_req = 1'b1;
    dat_we = 1'b1;
    dat_addr = a;
    dat_wdata = v;
    for (i = 0; i < 40; i++) begin
      tick(1);
      if (dat_done === 1'b1) break;
    end
    dat_req = 1'b0;
    dat_we = 1'b0;
    if (i == 40) error_cnt++;
    `PFBC_CHK(pm_wdata, v)
    `PFBC_CHK(pm_addr, a)
    `PFBC_CHK(pm_code, 1'b0)
    `PFBC_CHK(last_len, exp_len)
  endtask

  task automatic t_reset();
    int n;
    `PFBC_CHK(bcr_rdata, BCR_RST_5V)
    `PFBC_CHK(pm_rd, 1'b0)
    n = 0;
    repeat (40) begin
      tick(1);
      if (mcycle_tick === 1'b1) n++;
    end
    `PFBC_CHK(n, 40 / MCYCLE_CLKS)
  endtask

  task automatic t_fill_and_stream();
    do_branch(16'h0100, 1'b0);
    base = code_reads;
    tick(100);
    `PFBC_CHK(code_reads - base, QDEPTH)
    `PFBC_CHK(last_len, WAITS_5V + 1)
    fetch(3);
    fetch(2);
    fetch(1);
    fetch(1);
  endtask

  task automatic t_stall_then_hit();
    do_branch(16'h0300, 1'b0);
    fetch(3);
    `PFBC_CHK(stall_seen, 1'b1)
    tick(100);
    do_branch(16'h0100, 1'b1);
    fetch(3);
    `PFBC_CHK(stall_seen, 1'b0)
    fetch(3);
  endtask

  task automatic t_lru();
    do_branch(16'h0400, 1'b0);
    tick(100);
    do_branch(16'h0500, 1'b0);
    tick(100);
    do_branch(16'h0600, 1'b0);
    tick(100);
    do_branch(16'h0300, 1'b0);
    tick(100);
    do_branch(16'h0500, 1'b1);
    tick(100);
  endtask

  task automatic t_disable();
    bcr_write(8'h04);
    do_branch(16'h0500, 1'b0);
    base = code_reads;
    tick(100);
    `PFBC_CHK(code_reads - base, 0)
    fetch(1);
    `PFBC_CHK(code_reads - base, 1)
    bcr_write(8'h82);
    do_branch(16'h0500, 1'b0);
    tick(100);
    `PFBC_CHK(last_len, 3)
    fetch(2);
  endtask

  task automatic t_data();
    bcr_write(8'h8a);
    tick(50);
    data_read(16'h1234, 3);
    bcr_write(8'hca);
    tick(50);
    data_read(16'h2345, 2);
    data_write(16'h2400, 8'h3c, 2);
  endtask

  initial begin
    error_cnt = 0;
    total_checks = 0;
    rd_run = 0;
    last_len = 0;
    code_reads = 0;
    rd_prev = 1'b0;
    sys_rst = 1'b1;
    bcr_wr = 1'b0;
    bcr_wdata = 8'h00;
    branch_req = 1'b0;
    branch_addr = 16'h0000;
    fetch_req = 1'b0;
    fetch_len = 2'h0;
    dat_req = 1'b0;
    dat_we = 1'b0;
    dat_addr = 16'h0000;
    dat_wdata = 8'h00;
    pc = 16'h0000;
    tick(20);
    sys_rst = 1'b0;
    t_reset();
    t_fill_and_stream();
    t_stall_then_hit();
    t_lru();
    t_disable();
    t_data();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
endmodule : prefetch_queue_branch_cache_test
`default_nettype wire
